// file: design/rf_receive_indicator_framer.sv
// ------------------------------------------------------------------
// payload fifo
// ------------------------------------------------------------------
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
module byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input  wire logic         core_clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] inData,
  input  wire logic         inValid,
  output logic              inReady,
  output logic [W-1:0]      outData,
  output logic              outValid,
  input  wire logic         outReady
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("fifo depth must be a power of two");
  end

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          inReady_q, inReady_d, outValid_q, outValid_d;
  logic          push, pop;

  always_comb begin
    push = inValid && inReady_q;
    pop = outValid_q && outReady;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    // flags registered so the ready seen upstream is a flop
    inReady_d = cnt_d != (AW+1)'(DEPTH);
    outValid_d = cnt_d != '0;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      inReady_q <= 1'b0;
      outValid_q <= 1'b0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      inReady_q <= inReady_d;
      outValid_q <= outValid_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_q] <= inData;
    end
  end

  assign inReady = inReady_q;
  assign outValid = outValid_q;
  assign outData = mem[rd_q];
endmodule : byte_fifo

// Summary of operation
// - With the format setting at zero each packet leaves as a frame of type 0x90.
// - The sender's 64-bit address fills offsets 4 to 11, most significant byte first.
// - In the standard frame the payload starts at offset 15 after two reserved bytes and the options byte.
// - Options bit 0, at offset 14 of the standard frame, is set for an acknowledged packet.
// - Options bit 1 is set for a broadcast packet.
// - Options bits 7:6 give the delivery method, mesh only where supported, and the host ignores other bits.
// - With the format setting at one each packet leaves as a frame of type 0x91.
// - The explicit frame carries the endpoints and cluster set on the sender, not defaults.
// - The explicit frame carries the source endpoint at offset 14.
// - The explicit frame carries the destination endpoint at offset 15.
// - The explicit frame carries the cluster identifier at offsets 16 and 17.
// - The explicit frame carries the profile identifier at offsets 18 and 19.
// - The explicit frame carries options at offset 20 and payload from 21, spare bits ignored by the host.
module rf_receive_indicator_framer #(
  parameter logic MESH_OK = 1'b1,
  parameter int   DEPTH   = rx_framer_pkg::FIFO_DEPTH
) (
  input  wire logic                   core_clk,
  input  wire logic                   resetn,
  input  wire logic [11:0]            awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [31:0]            wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [11:0]            araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [31:0]                 rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire rx_framer_pkg::rx_hdr_t hdrIn,
  input  wire logic                   hdrValid,
  output logic                        hdrReady,
  input  wire logic [7:0]             payData,
  input  wire logic                   payValid,
  output logic                        payReady,
  output logic [7:0]                  txData,
  output logic                        txValid,
  output logic                        txLast,
  input  wire logic                   txReady
);
  if (DEPTH < 2) begin : g_chk
    $error("payload fifo too shallow");
  end

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  logic        awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [11:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d;
  logic [3:0]  wStrb_q, wStrb_d;
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        bvalid_q, bvalid_d, arready_q, arready_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d, count_q, count_d;
  logic        fmtSel_q, fmtSel_d;
  logic [11:0] wa, ra;
  rx_framer_pkg::frm_state_t state_q, state_d;
  logic        fifoValid;

  always_comb begin
    awHeld_d = awHeld_q;
    awAddr_d = awAddr_q;
    wHeld_d = wHeld_q;
    wData_d = wData_q;
    wStrb_d = wStrb_q;
    bvalid_d = bvalid_q && !bready;
    bresp_d = bresp_q;
    fmtSel_d = fmtSel_q;
    if (awvalid && awready_q) begin
      awHeld_d = 1'b1;
      awAddr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      wHeld_d = 1'b1;
      wData_d = wdata;
      wStrb_d = wstrb;
    end
    wa = {awAddr_d[11:2], 2'h0};
    if (awHeld_d && wHeld_d && !bvalid_q) begin
      awHeld_d = 1'b0;
      wHeld_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = rx_framer_pkg::RESP_SLVERR;
      if (wa == rx_framer_pkg::REG_CTRL) begin
        bresp_d = rx_framer_pkg::RESP_OKAY;
        if (wStrb_d[0]) begin
          fmtSel_d = wData_d[rx_framer_pkg::CTRL_FMT_BIT];
        end
      end
    end
    awready_d = !awHeld_d && !bvalid_d;
    wready_d = !wHeld_d && !bvalid_d;
  end

  always_comb begin
    rvalid_d = rvalid_q && !rready;
    rdata_d = rvalid_d ? rdata_q : 32'h0;
    rresp_d = rresp_q;
    ra = {araddr[11:2], 2'h0};
    if (arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d = rx_framer_pkg::RESP_OKAY;
      if (ra == rx_framer_pkg::REG_CTRL) begin
        rdata_d = {31'h0, fmtSel_q};
      end else if (ra == rx_framer_pkg::REG_STATUS) begin
        rdata_d = {30'h0, fifoValid,
                   state_q != rx_framer_pkg::S_IDLE};
      end else if (ra == rx_framer_pkg::REG_COUNT) begin
        rdata_d = count_q;
      end else begin
        rdata_d = 32'h0;
        rresp_d = rx_framer_pkg::RESP_SLVERR;
      end
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      awHeld_q <= 1'b0;
      awAddr_q <= 12'h0;
      wHeld_q <= 1'b0;
      wData_q <= 32'h0;
      wStrb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= 2'h0;
      fmtSel_q <= rx_framer_pkg::CTRL_FMT_RST;
    end else begin
      awHeld_q <= awHeld_d;
      awAddr_q <= awAddr_d;
      wHeld_q <= wHeld_d;
      wData_q <= wData_d;
      wStrb_q <= wStrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      fmtSel_q <= fmtSel_d;
    end
  end

  // ----------------------------------------------------------------
  // payload buffer
  // ----------------------------------------------------------------
  logic [7:0] fifoData;
  logic       pop;

  byte_fifo #(.W(8), .DEPTH(DEPTH)) u_fifo (
    .core_clk (core_clk),
    .resetn   (resetn),
    .inData   (payData),
    .inValid  (payValid),
    .inReady  (payReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (pop)
  );

  // ----------------------------------------------------------------
  // framer
  // ----------------------------------------------------------------
  rx_framer_pkg::rx_hdr_t hdr_q, hdr_d;
  logic        fmt_q, fmt_d, free, txValid_q, txValid_d, txLast_q;
  logic        txLast_d, hdrReady_q, hdrReady_d;
  logic [7:0]  txData_q, txData_d, csum_q, csum_d, opts, hb;
  logic [15:0] len_q, len_d, payCnt_q, payCnt_d;
  logic [4:0]  idx_q, idx_d, hdrLen;

  function automatic logic [7:0] hdrByte(
    input logic [4:0]             i,
    input logic                   x,
    input rx_framer_pkg::rx_hdr_t h,
    input logic [7:0]             o
  );
    logic [7:0] b;
    b = o;
    if (i == 5'h0) begin
      b = x ? rx_framer_pkg::TYPE_EXP : rx_framer_pkg::TYPE_STD;
    end else if (i <= 5'h8) begin
      b = h.srcAddr[8*(8-int'(i)) +: 8];
    end else if (i == 5'h9) begin
      b = rx_framer_pkg::RSV_HI;
    end else if (i == 5'ha) begin
      b = rx_framer_pkg::RSV_LO;
    end else if (x) begin
      // endpoints and ids pass through as the sender set them
      case (i)
        5'hb: b = h.sourceEndpoint;
        5'hc: b = h.destinationEndpoint;
        5'hd: b = h.clusterIdentifier[15:8];
        5'he: b = h.clusterIdentifier[7:0];
        5'hf: b = h.profileId[15:8];
        5'h10: b = h.profileId[7:0];
        default: b = o;
      endcase
    end
    return b;
  endfunction : hdrByte

  always_comb begin
    // spare option bits always sent as zero
    opts = {hdr_q.mode, 4'h0, hdr_q.bcast, hdr_q.acked};
    if (!MESH_OK && hdr_q.mode == rx_framer_pkg::MODE_MESH) begin
      opts[7:6] = 2'h0;
    end
    hdrLen = fmt_q ? rx_framer_pkg::HDR_LEN_EXP
                   : rx_framer_pkg::HDR_LEN_STD;
    hb = hdrByte(idx_q, fmt_q, hdr_q, opts);
    free = !txValid_q || txReady;
    state_d = state_q;
    hdr_d = hdr_q;
    fmt_d = fmt_q;
    len_d = len_q;
    idx_d = idx_q;
    payCnt_d = payCnt_q;
    csum_d = csum_q;
    count_d = count_q;
    txValid_d = txValid_q && !txReady;
    txData_d = txData_q;
    txLast_d = txLast_q && !txReady;
    pop = 1'b0;
    case (state_q)
      rx_framer_pkg::S_IDLE: begin
        if (hdrValid && hdrReady_q) begin
          hdr_d = hdrIn;
          fmt_d = fmtSel_q;
          len_d = 16'(fmtSel_q ? rx_framer_pkg::HDR_LEN_EXP
                               : rx_framer_pkg::HDR_LEN_STD)
                  + hdrIn.payLen;
          state_d = rx_framer_pkg::S_DELIM;
        end
      end
      rx_framer_pkg::S_DELIM: begin
        if (free) begin
          txValid_d = 1'b1;
          txData_d = rx_framer_pkg::START_DELIM;
          state_d = rx_framer_pkg::S_LEN_HI;
        end
      end
      rx_framer_pkg::S_LEN_HI: begin
        if (free) begin
          txValid_d = 1'b1;
          txData_d = len_q[15:8];
          state_d = rx_framer_pkg::S_LEN_LO;
        end
      end
      rx_framer_pkg::S_LEN_LO: begin
        if (free) begin
          txValid_d = 1'b1;
          txData_d = len_q[7:0];
          idx_d = 5'h0;
          csum_d = 8'h0;
          state_d = rx_framer_pkg::S_HDR;
        end
      end
      rx_framer_pkg::S_HDR: begin
        if (free) begin
          txValid_d = 1'b1;
          txData_d = hb;
          csum_d = csum_q + hb;
          idx_d = idx_q + 5'h1;
          payCnt_d = 16'h0;
          if (idx_q == hdrLen - 5'h1) begin
            state_d = (hdr_q.payLen == 16'h0) ? rx_framer_pkg::S_CSUM
                                               : rx_framer_pkg::S_PAY;
          end
        end
      end
      rx_framer_pkg::S_PAY: begin
        // an empty fifo stalls the frame; the host sees a gap
        if (free && fifoValid) begin
          pop = 1'b1;
          txValid_d = 1'b1;
          txData_d = fifoData;
          csum_d = csum_q + fifoData;
          payCnt_d = payCnt_q + 16'h1;
          if (payCnt_q == hdr_q.payLen - 16'h1) begin
            state_d = rx_framer_pkg::S_CSUM;
          end
        end
      end
      rx_framer_pkg::S_CSUM: begin
        if (free) begin
          txValid_d = 1'b1;
          txData_d = rx_framer_pkg::CSUM_BASE - csum_q;
          txLast_d = 1'b1;
          count_d = count_q + 32'h1;
          state_d = rx_framer_pkg::S_IDLE;
        end
      end
      default: state_d = rx_framer_pkg::S_IDLE;
    endcase
    // no new header while the checksum waits: len_q must hold until it goes
    hdrReady_d = state_d == rx_framer_pkg::S_IDLE && !txLast_d
                 && !(hdrValid && hdrReady_q);
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= rx_framer_pkg::S_IDLE;
      hdr_q <= '0;
      fmt_q <= 1'b0;
      len_q <= 16'h0;
      idx_q <= 5'h0;
      payCnt_q <= 16'h0;
      csum_q <= 8'h0;
      count_q <= 32'h0;
      txValid_q <= 1'b0;
      txData_q <= 8'h0;
      txLast_q <= 1'b0;
      hdrReady_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hdr_q <= hdr_d;
      fmt_q <= fmt_d;
      len_q <= len_d;
      idx_q <= idx_d;
      payCnt_q <= payCnt_d;
      csum_q <= csum_d;
      count_q <= count_d;
      txValid_q <= txValid_d;
      txData_q <= txData_d;
      txLast_q <= txLast_d;
      hdrReady_q <= hdrReady_d;
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign hdrReady = hdrReady_q;
  assign txValid = txValid_q;
  assign txData = txData_q;
  assign txLast = txLast_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [15:0] off_q;
  logic        hs;
  assign hs = txValid_q && txReady;
  always_ff @(posedge core_clk) begin
    if (!resetn || (hs && txLast_q)) begin
      off_q <= 16'h0;
    end else if (hs) begin
      off_q <= off_q + 16'h1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_delim_first: assert property (
    hs && off_q == 16'h0 |-> txData_q == 8'h7e)
    else $error("bad delimiter");
  a_std_type: assert property (
    hs && off_q == 16'h3 && !fmt_q |-> txData_q == 8'h90)
    else $error("bad std type");
  a_exp_type: assert property (
    hs && off_q == 16'h3 && fmt_q |-> txData_q == 8'h91)
    else $error("bad exp type");
  a_addr_msb: assert property (
    hs && off_q == 16'h4 |-> txData_q == hdr_q.srcAddr[63:56])
    else $error("bad address msb");
  a_addr_lsb: assert property (
    hs && off_q == 16'hb |-> txData_q == hdr_q.srcAddr[7:0])
    else $error("bad address lsb");
  a_std_opts: assert property (
    hs && off_q == 16'he && !fmt_q
    |-> txData_q[1:0] == {hdr_q.bcast, hdr_q.acked})
    else $error("bad std options");
  a_bcast_bit: assert property (
    hs && off_q == 16'h14 && fmt_q |-> txData_q[1] == hdr_q.bcast)
    else $error("bad broadcast bit");
  // checked on every standard frame, not only where mesh is barred
  a_mesh_mask: assert property (
    hs && off_q == 16'he && !fmt_q
    |-> txData_q[7:6] == ((!MESH_OK && hdr_q.mode == 2'h3) ? 2'h0
                          : hdr_q.mode))
    else $error("bad delivery code");
  a_src_ep: assert property (
    hs && off_q == 16'he && fmt_q |-> txData_q == hdr_q.sourceEndpoint)
    else $error("bad source endpoint");
  a_dst_ep: assert property (
    hs && off_q == 16'hf && fmt_q
    |-> txData_q == hdr_q.destinationEndpoint)
    else $error("bad dest endpoint");
  a_cluster_msb: assert property (
    hs && off_q == 16'h10 && fmt_q
    |-> txData_q == hdr_q.clusterIdentifier[15:8])
    else $error("bad cluster");
  a_profile_lsb: assert property (
    hs && off_q == 16'h13 && fmt_q |-> txData_q == hdr_q.profileId[7:0])
    else $error("bad profile");
  a_frame_len: assert property (
    hs && txLast_q |-> off_q == len_q + 16'h3)
    else $error("length mismatch");
  a_out_hold: assert property (
    txValid_q && !txReady |=> txValid_q && $stable(txData_q))
    else $error("output dropped");

  c_std_frame: cover property (hs && txLast_q && !fmt_q);
  c_exp_frame: cover property (hs && txLast_q && fmt_q);
  c_empty_pay: cover property (hs && txLast_q && hdr_q.payLen == 16'h0);
  c_stall: cover property (txValid_q && !txReady ##1 hs);
endmodule : rf_receive_indicator_framer

// file: shared/rx_framer_pkg.sv
package rx_framer_pkg;

  // ----------------------------------------------------------------
  // frame constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  START_DELIM  = 8'h7e;
  localparam logic [7:0]  TYPE_STD     = 8'h90;
  localparam logic [7:0]  TYPE_EXP     = 8'h91;
  localparam logic [7:0]  RSV_HI       = 8'hff;
  localparam logic [7:0]  RSV_LO       = 8'hfe;
  localparam logic [7:0]  CSUM_BASE    = 8'hff;
  localparam logic [4:0]  HDR_LEN_STD  = 5'h0c;
  localparam logic [4:0]  HDR_LEN_EXP  = 5'h12;
  localparam logic [1:0]  MODE_MESH    = 2'h3;
  localparam int          FIFO_DEPTH   = 32;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_STATUS   = 12'h004;
  localparam logic [11:0] REG_COUNT    = 12'h008;
  localparam int          CTRL_FMT_BIT = 0;
  localparam logic        CTRL_FMT_RST = 1'h0;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [63:0] srcAddr;
    logic [7:0]  sourceEndpoint;
    logic [7:0]  destinationEndpoint;
    logic [15:0] clusterIdentifier;
    logic [15:0] profileId;
    logic        acked;
    logic        bcast;
    logic [1:0]  mode;
    logic [15:0] payLen;
  } rx_hdr_t;

  typedef enum logic [2:0] {
    S_IDLE, S_DELIM, S_LEN_HI, S_LEN_LO, S_HDR, S_PAY, S_CSUM
  } frm_state_t;

endpackage : rx_framer_pkg

// file: verification/host_model.sv
// ------------------------------------------------------------------
// serial host: collects frame bytes and can stall the stream
// ------------------------------------------------------------------
module host_model (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  input  wire logic       txLast,
  input  wire logic       slow,
  output logic            txReady
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] rxq[$];
  int         frames;
  logic [1:0] ph;

  // slow mode takes one byte in four, so the payload fifo backs up
  always @(posedge core_clk) begin
    if (!resetn) begin
      txReady <= 1'b0;
      ph      <= 2'h0;
      frames  <= 0;
    end else begin
      ph      <= ph + 2'h1;
      txReady <= !slow || ph == 2'h3;
      // bytes are kept raw; the bench reads ids and options itself
      if (txValid && txReady) begin
        rxq.push_back(txData);
        if (txLast) begin
          frames <= frames + 1;
        end
      end
    end
  end
endmodule : host_model

// file: verification/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, slow;
  logic        hdrValid, hdrReady, payValid, payReady;
  logic        txValid, txLast, txReady;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  logic [7:0]  payData, txData;
  logic [7:0]  got[$], exp[$];
  int          err_count, compares, nFrm, stalls, m;
  rx_framer_pkg::rx_hdr_t hdrIn;

  rf_receive_indicator_framer rf_receive_indicator_framer_inst (
    .core_clk(core_clk), .resetn(resetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .hdrIn(hdrIn), .hdrValid(hdrValid),
    .hdrReady(hdrReady), .payData(payData), .payValid(payValid),
    .payReady(payReady), .txData(txData), .txValid(txValid),
    .txLast(txLast), .txReady(txReady));

  host_model host_model_inst (
    .core_clk(core_clk), .resetn(resetn), .txData(txData),
    .txValid(txValid), .txLast(txLast), .slow(slow), .txReady(txReady));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task summarize;
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    compares++;
    if (seen !== ex) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask : chk

  // bounded waits: a hang ends the run through the report
  task tmo(input int n);
    if (n > 3000) begin
      err_count++;
      $display("Error wait expected done seen timeout");
      summarize();
    end
  endtask : tmo

  task axw(input logic [11:0] a, input logic [31:0] d,
           output logic [1:0] r);
    int n;
    n = 0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      tmo(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge core_clk);
  endtask : axw

  task axr(input logic [11:0] a);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      tmo(n);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask : axr

  task push(input logic [7:0] b);
    int n;
    n = 0;
    payData  <= b;
    payValid <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      tmo(n);
      if (!payReady) stalls++;
    end while (!payReady);
  endtask : push

  // one packet in, one frame out, whole frame compared byte by byte
  task pkt(input logic [63:0] a, input logic [47:0] ids,
           input logic [7:0] o, input int n, input logic f);
    int i, k;
    logic [7:0] s;
    exp = {8'h7e, 8'h00, 8'h00};
    exp.push_back(f ? rx_framer_pkg::TYPE_EXP : rx_framer_pkg::TYPE_STD);
    for (i = 7; i >= 0; i--) exp.push_back(a[i*8+:8]);
    exp.push_back(8'hff);
    exp.push_back(8'hfe);
    if (f) for (i = 5; i >= 0; i--) exp.push_back(ids[i*8+:8]);
    exp.push_back(o);
    for (i = 0; i < n; i++) exp.push_back(8'(i * 7 + 3));
    exp[2] = 8'(exp.size() - 3);
    s = 8'hff;
    for (i = 3; i < exp.size(); i++) s -= exp[i];
    exp.push_back(s);
    hdrIn <= '{a, ids[47:40], ids[39:32], ids[31:16], ids[15:0],
               o[0], o[1], o[7:6], 16'(n)};
    hdrValid <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
      tmo(k);
    end while (!hdrReady);
    hdrValid <= 1'b0;
    for (i = 0; i < n; i++) push(8'(i * 7 + 3));
    payValid <= 1'b0;
    nFrm++;
    k = 0;
    while (host_model_inst.frames != nFrm) begin
      @(posedge core_clk);
      k++;
      tmo(k);
    end
    got = {};
    repeat (exp.size()) got.push_back(host_model_inst.rxq.pop_front());
    for (i = 0; i < exp.size(); i++) chk("byte", got[i], exp[i]);
    chk("extra bytes", host_model_inst.rxq.size(), 0);
    @(posedge core_clk);
  endtask : pkt

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, slow} = '0;
    {hdrValid, payValid, awaddr, araddr, wdata, wstrb, payData} = '0;
    hdrIn = '0;
    err_count = 0;
    compares = 0;
    nFrm = 0;
    stalls = 0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    axr(rx_framer_pkg::REG_CTRL);
    chk("ctrl reset", rd, {31'h0, rx_framer_pkg::CTRL_FMT_RST});
    axr(rx_framer_pkg::REG_COUNT);
    chk("count reset", rd, 32'h0);
    axr(12'h00c);
    chk("unmapped resp", rs, rx_framer_pkg::RESP_SLVERR);
    axw(rx_framer_pkg::REG_STATUS, 32'h1, rs);
    chk("ro write resp", rs, rx_framer_pkg::RESP_SLVERR);
    $display("test registers done");
    pkt(64'h0013a20040522baa, 48'h0, 8'h01, 6, 1'b0);
    chk("std type", got[3], 8'h90);
    chk("std options", got[14], 8'h01);
    chk("std payload", got[15], 8'h03);
    $display("test standard frame done");
    for (m = 0; m < 4; m++) begin
      pkt(64'h8000000000000001, 48'h0, {m[1:0], 6'h02}, 1, 1'b0);
      chk("mode options", got[14], {m[1:0], 6'h02});
    end
    $display("test delivery modes done");
    slow <= 1'b1;
    axw(rx_framer_pkg::REG_CTRL, 32'h1, rs);
    chk("ctrl write resp", rs, rx_framer_pkg::RESP_OKAY);
    axr(rx_framer_pkg::REG_CTRL);
    chk("ctrl readback", rd, 32'h1);
    pkt(64'h0013a20040522baa, 48'he0e02211c105, 8'h02, 6, 1'b1);
    chk("exp type", got[3], 8'h91);
    chk("endpoints", {got[14], got[15]}, 16'he0e0);
    chk("cluster", {got[16], got[17]}, 16'h2211);
    chk("profile", {got[18], got[19]}, 16'hc105);
    chk("exp options", got[20], 8'h02);
    chk("exp payload", got[21], 8'h03);
    $display("test explicit frame done");
    stalls = 0;
    pkt(64'hfedcba9876543210, 48'h0102a5a55a5a, 8'hc1, 60, 1'b1);
    chk("fifo refused", {31'h0, stalls != 0}, 32'h1);
    axr(rx_framer_pkg::REG_STATUS);
    chk("status idle", rd, 32'h0);
    axr(rx_framer_pkg::REG_COUNT);
    chk("frame count", rd, 32'(nFrm));
    $display("test fifo fill done");
    summarize();
  end
endmodule : testbench
